// ==== include/asp_pkg.sv ====
// Functional notes
// [RULE1] The API receive side has a serial data input plus an active-low request line and an active-low clear line.
// [RULE2] The API transmit side has a serial data output, an active-low request driven by the device and an active-low clear driven by the companion.
// [RULE3] The API port runs at 115200 baud with level flow control on transmit and none required on receive.
// [RULE4] API packets are HDLC framed and every character has one stop bit and no parity.
// [RULE5] The receive request and clear lines are optional and the port works when they are unused.
// [RULE6] The device starts every outgoing packet by driving its request low before any data.
// [RULE7] The companion drives the transmit clear low when ready, or ties it low if always ready.
// [RULE8] Once clear is seen low while request is asserted, the whole packet is sent without further handshake pauses.
// [RULE9] After the last byte the request is released and held high for at least a configurable minimum before the next assertion.
// [RULE10] A companion driving the transmit clear releases it before packet end and waits the inter-packet gap before the next exchange.
// [RULE11] Both ports watch their lines continuously, idle in lowest power and return to it after a transfer.
// [RULE12] The console port is a two-wire 9600 baud link with one stop bit and no parity carrying command traffic.
// [RULE13] In doze the device keeps its state, detects serial activity and wakes quickly.
// [RULE14] The companion holds every unused handshake input at its inactive level.
// [RULE15] Each character is eight data bits, LSB first, after one low start bit.
// [RULE16] HDLC frames are delimited by 0x7E and inner flag or escape bytes are escaped with 0x7D.
package asp_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int API_BAUD = 115200;
  localparam int CON_BAUD = 9600;
  localparam int API_DIV = CLK_HZ / API_BAUD;
  localparam int CON_DIV = CLK_HZ / CON_BAUD;
  localparam int DIV_W = 16;
  localparam int GAP_NS = 100000;
  localparam int GAP_CYC = (GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int GAP_W = 16;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [7:0] HDLC_ESC = 8'h7D;
  localparam logic [7:0] HDLC_XOR = 8'h20;
  localparam int IDLE_BITS = 12;
  typedef enum logic [2:0] {ASP_TX_IDLE, ASP_TX_REQ, ASP_TX_OPEN, ASP_TX_DATA,
                            ASP_TX_CLOSE, ASP_TX_GAP} asp_tx_state_t;
  typedef enum logic [1:0] {ASP_RX_HUNT, ASP_RX_BODY, ASP_RX_ESC} asp_rx_state_t;
endpackage

// ==== core/asp_uart_tx.sv ====
`timescale 1ns/1ps
module asp_uart_tx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Baud setting
  input wire logic [15:0] div,
  // Byte in
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy_ff,
  // Line
  output logic line_ff
);
  logic [15:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [9:0] sh_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
      cnt_ff <= 16'h0000;
      bit_ff <= 4'h0;
      sh_ff <= 10'h3FF;
    end else if (!busy_ff) begin
      line_ff <= 1'b1;
      if (start) begin
        // Stop, data LSB first, start
        sh_ff <= {1'b1, data, 1'b0}; // [RULE15] [RULE4]
        busy_ff <= 1'b1;
        cnt_ff <= 16'h0000;
        bit_ff <= 4'h0;
      end
    end else begin
      line_ff <= sh_ff[0];
      if (cnt_ff == div - 16'h0001) begin
        cnt_ff <= 16'h0000;
        sh_ff <= {1'b1, sh_ff[9:1]};
        if (bit_ff == 4'h9) begin
          busy_ff <= 1'b0;
        end
        bit_ff <= bit_ff + 4'h1;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule

// ==== core/asp_uart_rx.sv ====
`timescale 1ns/1ps
module asp_uart_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Baud setting
  input wire logic [15:0] div,
  // Synchronised line
  input wire logic line,
  // Byte out
  output logic valid_ff,
  output logic [7:0] data_ff,
  output logic active_ff
);
  logic [15:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      data_ff <= 8'h00;
      active_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
    end else begin
      valid_ff <= 1'b0;
      if (!active_ff) begin
        // Idle until a falling start edge wakes the receiver
        if (!line) begin // [RULE11]
          active_ff <= 1'b1;
          cnt_ff <= {1'b0, div[15:1]};
          bit_ff <= 4'h0;
        end
      end else if (cnt_ff == 16'h0000) begin
        cnt_ff <= div - 16'h0001;
        bit_ff <= bit_ff + 4'h1;
        if (bit_ff == 4'h0 && line) begin
          active_ff <= 1'b0;
        end else if (bit_ff >= 4'h1 && bit_ff <= 4'h8) begin
          sh_ff <= {line, sh_ff[7:1]}; // [RULE15]
        end else if (bit_ff == 4'h9) begin
          // Bad stop bit drops the byte; no parity is checked
          active_ff <= 1'b0;
          if (line) begin // [RULE4] [RULE12]
            valid_ff <= 1'b1;
            data_ff <= sh_ff;
          end
        end
      end else begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end
endmodule

// ==== core/asp_serial_port.sv ====
`timescale 1ns/1ps
module asp_serial_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Minimum request-high time after a packet, in cycles
  input wire logic [15:0] min_gap_cycles,
  // API transmit packet stream from device core
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready_ff,
  // API receive packet stream to device core
  output logic rx_valid_ff,
  output logic [7:0] rx_byte_ff,
  output logic rx_end_ff,
  // API pins
  input wire logic api_serial_in,
  input wire logic api_in_request_low,
  output logic api_in_grant_low_ff,
  output logic api_serial_out_ff,
  output logic api_out_request_low_ff,
  input wire logic api_out_grant_low,
  // Console pins and byte streams
  input wire logic console_serial_in,
  output logic console_serial_out_ff,
  input wire logic con_tx_valid,
  input wire logic [7:0] con_tx_byte,
  output logic con_tx_ready_ff,
  output logic con_rx_valid_ff,
  output logic [7:0] con_rx_byte_ff,
  // Power state
  output logic doze_ff
);
  asp_pkg::asp_tx_state_t st_ff;
  asp_pkg::asp_rx_state_t rst_ff;
  logic [1:0] s_rx_ff, s_rreq_ff, s_grant_ff, s_con_ff;
  logic [15:0] gap_ff;
  logic [7:0] hold_ff;
  logic hold_last_ff, hold_esc_ff, hold_full_ff;
  logic utx_start, utx_busy, utx_line, utx_busy_d_ff;
  logic [7:0] utx_data;
  logic urx_valid, urx_active;
  logic [7:0] urx_data;
  logic ctx_busy, ctx_line, ctx_busy_d_ff, ctx_start;
  logic crx_valid, crx_active;
  logic [7:0] crx_data;
  logic [15:0] idle_ff;
  logic any_act;

  function automatic logic needs_esc(input logic [7:0] b);
    needs_esc = (b == asp_pkg::HDLC_FLAG) || (b == asp_pkg::HDLC_ESC); // [RULE16]
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_rx_ff <= 2'b11;
      s_rreq_ff <= 2'b11;
      s_grant_ff <= 2'b11;
      s_con_ff <= 2'b11;
    end else begin
      s_rx_ff <= {s_rx_ff[0], api_serial_in};
      s_rreq_ff <= {s_rreq_ff[0], api_in_request_low}; // [RULE1]
      s_grant_ff <= {s_grant_ff[0], api_out_grant_low}; // [RULE2]
      s_con_ff <= {s_con_ff[0], console_serial_in};
    end
  end

  asp_uart_tx u_api_tx (
    .clk(clk),
    .rst_n(rst_n),
    .div(16'(asp_pkg::API_DIV)), // [RULE3]
    .start(utx_start),
    .data(utx_data),
    .busy_ff(utx_busy),
    .line_ff(utx_line)
  );

  asp_uart_rx u_api_rx (
    .clk(clk),
    .rst_n(rst_n),
    .div(16'(asp_pkg::API_DIV)),
    .line(s_rx_ff[1]),
    .valid_ff(urx_valid),
    .data_ff(urx_data),
    .active_ff(urx_active)
  );

  asp_uart_tx u_con_tx (
    .clk(clk),
    .rst_n(rst_n),
    .div(16'(asp_pkg::CON_DIV)), // [RULE12]
    .start(ctx_start),
    .data(con_tx_byte),
    .busy_ff(ctx_busy),
    .line_ff(ctx_line)
  );

  asp_uart_rx u_con_rx (
    .clk(clk),
    .rst_n(rst_n),
    .div(16'(asp_pkg::CON_DIV)),
    .line(s_con_ff[1]),
    .valid_ff(crx_valid),
    .data_ff(crx_data),
    .active_ff(crx_active)
  );

  // The UART busy flag rises one cycle after start; the delayed copy bridges that gap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      utx_busy_d_ff <= 1'b0;
      ctx_busy_d_ff <= 1'b0;
    end else begin
      utx_busy_d_ff <= utx_start;
      ctx_busy_d_ff <= ctx_start;
    end
  end

  wire utx_free = !utx_busy && !utx_busy_d_ff;
  wire load = tx_valid && tx_ready_ff;

  // Transmit byte selection for the current state
  always_comb begin
    utx_start = 1'b0;
    utx_data = asp_pkg::HDLC_FLAG;
    if (utx_free) begin
      case (st_ff)
        asp_pkg::ASP_TX_OPEN: begin
          utx_start = 1'b1;
        end
        asp_pkg::ASP_TX_DATA: begin
          if (hold_full_ff) begin
            utx_start = 1'b1;
            if (needs_esc(hold_ff) && !hold_esc_ff) begin
              utx_data = asp_pkg::HDLC_ESC; // [RULE16]
            end else if (hold_esc_ff) begin
              utx_data = hold_ff ^ asp_pkg::HDLC_XOR;
            end else begin
              utx_data = hold_ff;
            end
          end
        end
        asp_pkg::ASP_TX_CLOSE: begin
          utx_start = 1'b1;
        end
        default: begin
          utx_start = 1'b0;
        end
      endcase
    end
  end

  // API transmit packet sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= asp_pkg::ASP_TX_IDLE;
      api_out_request_low_ff <= 1'b1;
      gap_ff <= 16'h0000;
      tx_ready_ff <= 1'b0;
      hold_ff <= 8'h00;
      hold_last_ff <= 1'b0;
      hold_esc_ff <= 1'b0;
      hold_full_ff <= 1'b0;
    end else begin
      case (st_ff)
        asp_pkg::ASP_TX_IDLE: begin
          if (tx_valid) begin
            api_out_request_low_ff <= 1'b0; // [RULE6]
            st_ff <= asp_pkg::ASP_TX_REQ;
          end
        end
        asp_pkg::ASP_TX_REQ: begin
          // A tied-low grant starts immediately
          if (!s_grant_ff[1]) begin // [RULE7] [RULE8]
            st_ff <= asp_pkg::ASP_TX_OPEN;
          end
        end
        asp_pkg::ASP_TX_OPEN: begin
          if (utx_start) begin
            st_ff <= asp_pkg::ASP_TX_DATA;
            tx_ready_ff <= 1'b1;
          end
        end
        asp_pkg::ASP_TX_DATA: begin
          // Grant is no longer looked at: the companion may drop it mid-packet
          if (load) begin // [RULE8] [RULE10]
            hold_ff <= tx_byte;
            hold_last_ff <= tx_last;
            hold_full_ff <= 1'b1;
            hold_esc_ff <= 1'b0;
            tx_ready_ff <= 1'b0;
          end else if (utx_start) begin
            if (needs_esc(hold_ff) && !hold_esc_ff) begin
              hold_esc_ff <= 1'b1;
            end else begin
              hold_full_ff <= 1'b0;
              hold_esc_ff <= 1'b0;
              if (hold_last_ff) begin
                st_ff <= asp_pkg::ASP_TX_CLOSE;
              end else begin
                tx_ready_ff <= 1'b1;
              end
            end
          end
        end
        asp_pkg::ASP_TX_CLOSE: begin
          if (utx_start) begin
            st_ff <= asp_pkg::ASP_TX_GAP;
          end
        end
        asp_pkg::ASP_TX_GAP: begin
          // Release only after the closing flag leaves the wire
          if (api_out_request_low_ff && utx_free) begin
            if (gap_ff + 16'h0001 >= min_gap_cycles) begin // [RULE9]
              st_ff <= asp_pkg::ASP_TX_IDLE;
            end
            gap_ff <= gap_ff + 16'h0001;
          end else if (utx_free) begin
            api_out_request_low_ff <= 1'b1; // [RULE9]
            gap_ff <= 16'h0000;
          end
        end
        default: begin
          st_ff <= asp_pkg::ASP_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      api_serial_out_ff <= 1'b1;
      console_serial_out_ff <= 1'b1;
      api_in_grant_low_ff <= 1'b1;
    end else begin
      api_serial_out_ff <= utx_line;
      console_serial_out_ff <= ctx_line; // [RULE12]
      // Receive always accepts; grant just mirrors the optional request
      api_in_grant_low_ff <= s_rreq_ff[1]; // [RULE5] [RULE3]
    end
  end

  // HDLC receive deframer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_ff <= asp_pkg::ASP_RX_HUNT;
      rx_valid_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
      rx_end_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      rx_end_ff <= 1'b0;
      if (urx_valid) begin
        if (urx_data == asp_pkg::HDLC_FLAG) begin // [RULE4] [RULE16]
          rx_end_ff <= (rst_ff != asp_pkg::ASP_RX_HUNT);
          rst_ff <= asp_pkg::ASP_RX_BODY;
        end else if (rst_ff == asp_pkg::ASP_RX_ESC) begin
          rx_valid_ff <= 1'b1;
          rx_byte_ff <= urx_data ^ asp_pkg::HDLC_XOR;
          rst_ff <= asp_pkg::ASP_RX_BODY;
        end else if (urx_data == asp_pkg::HDLC_ESC) begin
          rst_ff <= (rst_ff == asp_pkg::ASP_RX_HUNT) ? asp_pkg::ASP_RX_HUNT
                                                      : asp_pkg::ASP_RX_ESC;
        end else if (rst_ff == asp_pkg::ASP_RX_BODY) begin
          rx_valid_ff <= 1'b1;
          rx_byte_ff <= urx_data;
        end
      end
    end
  end

  // Console byte streams
  assign ctx_start = con_tx_valid && con_tx_ready_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      con_tx_ready_ff <= 1'b0;
      con_rx_valid_ff <= 1'b0;
      con_rx_byte_ff <= 8'h00;
    end else begin
      con_tx_ready_ff <= !ctx_busy && !ctx_busy_d_ff && !ctx_start;
      con_rx_valid_ff <= crx_valid;
      if (crx_valid) begin
        con_rx_byte_ff <= crx_data;
      end
    end
  end

  // Doze tracker: activity on any input line except the transmit grant wakes at once, state is never cleared by doze
  assign any_act = urx_active || crx_active || !s_rx_ff[1] || !s_con_ff[1] ||
                   !s_rreq_ff[1] || (st_ff != asp_pkg::ASP_TX_IDLE) || tx_valid ||
                   con_tx_valid || ctx_busy;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_ff <= 16'h0000;
      doze_ff <= 1'b1;
    end else if (any_act) begin
      idle_ff <= 16'h0000;
      doze_ff <= 1'b0; // [RULE13] [RULE11]
    end else if (idle_ff == 16'(asp_pkg::API_DIV * asp_pkg::IDLE_BITS)) begin
      doze_ff <= 1'b1; // [RULE11]
    end else begin
      idle_ff <= idle_ff + 16'h0001;
    end
  end
endmodule

// ==== bench/asp_serial_port_chk.sv ====
`timescale 1ns/1ps
module asp_serial_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [15:0] min_gap_cycles,
  input wire logic tx_ready_ff,
  input wire logic rx_valid_ff,
  input wire logic rx_end_ff,
  input wire logic api_serial_in,
  input wire logic api_in_request_low,
  input wire logic api_in_grant_low_ff,
  input wire logic api_serial_out_ff,
  input wire logic api_out_request_low_ff,
  input wire logic console_serial_in,
  input wire logic console_serial_out_ff,
  input wire logic con_tx_ready_ff,
  input wire logic doze_ff
);
  // Some margin over the twelve quiet bit-times before doze must be back
  localparam int QUIET_LIMIT = 14 * asp_pkg::API_DIV;
  logic [15:0] high_cnt_ff;
  logic [15:0] quiet_cnt_ff;
  logic line_quiet;
  assign line_quiet = api_serial_in & api_serial_out_ff & api_out_request_low_ff &
                      console_serial_in & console_serial_out_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_cnt_ff <= 16'hFFFF;
    end else if (!api_out_request_low_ff) begin
      high_cnt_ff <= 16'h0000;
    end else if (high_cnt_ff != 16'hFFFF) begin
      high_cnt_ff <= high_cnt_ff + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n || !line_quiet) begin
      quiet_cnt_ff <= 16'h0000;
    end else if (quiet_cnt_ff != 16'hFFFF) begin
      quiet_cnt_ff <= quiet_cnt_ff + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REQ_LEADS_DATA: assert property ($fell(api_serial_out_ff) |->
    !api_out_request_low_ff && !$past(api_out_request_low_ff)) else $error("data before request");
  AST_IDLE_WITHOUT_REQ: assert property (api_out_request_low_ff |-> api_serial_out_ff)
    else $error("line active without request");
  AST_GAP_HELD: assert property ($fell(api_out_request_low_ff) |->
    high_cnt_ff >= min_gap_cycles) else $error("request gap too short");
  AST_START_BIT: assert property ($fell(api_serial_out_ff) |->
    ##300 !api_serial_out_ff ##300 !api_serial_out_ff) else $error("start bit too short");
  AST_READY_IN_PACKET: assert property (tx_ready_ff |-> !api_out_request_low_ff)
    else $error("byte taken outside packet");
  AST_GRANT_MIRROR: assert property ($changed(api_in_request_low) |->
    ##[1:4] (api_in_grant_low_ff == api_in_request_low)) else $error("receive grant late");
  AST_DOZE_WAKE: assert property ($fell(api_serial_in) |-> ##[1:6] !doze_ff)
    else $error("no wake on activity");
  AST_DOZE_RETURN: assert property (quiet_cnt_ff >= QUIET_LIMIT |-> doze_ff)
    else $error("no return to doze");
  AST_RX_PULSE: assert property (rx_valid_ff |=> !rx_valid_ff && !rx_end_ff)
    else $error("receive strobe too long");
  AST_CON_IDLE: assert property (con_tx_ready_ff |-> console_serial_out_ff)
    else $error("console busy while ready");
endmodule
bind asp_serial_port asp_serial_port_chk i_chk (
  .clk(clk), .rst_n(rst_n), .min_gap_cycles(min_gap_cycles), .tx_ready_ff(tx_ready_ff),
  .rx_valid_ff(rx_valid_ff), .rx_end_ff(rx_end_ff), .api_serial_in(api_serial_in),
  .api_in_request_low(api_in_request_low), .api_in_grant_low_ff(api_in_grant_low_ff),
  .api_serial_out_ff(api_serial_out_ff), .api_out_request_low_ff(api_out_request_low_ff),
  .console_serial_in(console_serial_in), .console_serial_out_ff(console_serial_out_ff),
  .con_tx_ready_ff(con_tx_ready_ff), .doze_ff(doze_ff)
);

// ==== bench/asp_companion.sv ====
`timescale 1ns/1ps
module asp_companion (
  // Clock
  input wire logic clk,
  // Device transmit side
  input wire logic line_from_dev,
  input wire logic request_low,
  output logic grant_low,
  // Device receive side
  output logic line_to_dev,
  // High ties the grant low
  input wire logic grant_tied
);
  logic [7:0] got[$];
  logic [7:0] shift;
  initial begin
    grant_low = 1'b1;
    line_to_dev = 1'b1;
  end
  // Slow grant, withdrawn at the first start bit to prove the packet runs on
  always begin
    @(negedge clk);
    if (grant_tied) begin
      grant_low = 1'b0;
    end else if (!request_low) begin
      repeat (1000) @(negedge clk);
      grant_low = 1'b0;
      wait (!line_from_dev);
      @(negedge clk);
      grant_low = 1'b1;
      wait (request_low);
    end
  end
  always begin
    @(negedge line_from_dev);
    repeat (asp_pkg::API_DIV / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (asp_pkg::API_DIV) @(posedge clk);
      shift[i] = line_from_dev;
    end
    repeat (asp_pkg::API_DIV) @(posedge clk);
    if (line_from_dev === 1'b1) begin
      got.push_back(shift);
    end
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      line_to_dev = frame[i];
      repeat (asp_pkg::API_DIV - 1) @(negedge clk);
    end
  endtask
endmodule

// ==== bench/asp_serial_port_tb.sv ====
`timescale 1ns/1ps
module asp_serial_port_tb;
  typedef struct {logic [7:0] b; logic last; logic [15:0] on_line; int n;} asp_row_t;
  // Packet bytes beside what must appear on the line for each
  asp_row_t rows[3] = '{'{8'h7E, 1'b0, 16'h7D5E, 2}, '{8'h7D, 1'b1, 16'h7D5D, 2},
                        '{8'h41, 1'b1, 16'h0041, 1}};
  logic [7:0] rx_in[4] = '{8'h7E, 8'h7D, 8'h5E, 8'h7E};
  logic clk, rst_n, tx_valid, tx_last, tx_ready_ff, rx_valid_ff, rx_end_ff;
  logic api_serial_in, api_in_request_low, api_in_grant_low_ff, api_serial_out_ff;
  logic api_out_request_low_ff, api_out_grant_low, console_serial_out_ff;
  logic con_tx_ready_ff, con_rx_valid_ff, doze_ff, grant_tied, con_in, con_tx_valid;
  logic [7:0] tx_byte, rx_byte_ff, con_rx_byte_ff, con_tx_byte;
  logic [7:0] rx_q[$];
  int miscompares, comparisons, cycles, rx_ends, k, con_rx_cnt;
  asp_serial_port i_dut (
    .clk(clk), .rst_n(rst_n), .min_gap_cycles(16'h01F4), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready_ff(tx_ready_ff), .rx_valid_ff(rx_valid_ff),
    .rx_byte_ff(rx_byte_ff), .rx_end_ff(rx_end_ff), .api_serial_in(api_serial_in),
    .api_in_request_low(api_in_request_low), .api_in_grant_low_ff(api_in_grant_low_ff),
    .api_serial_out_ff(api_serial_out_ff), .api_out_request_low_ff(api_out_request_low_ff),
    .api_out_grant_low(api_out_grant_low), .console_serial_in(con_in),
    .console_serial_out_ff(console_serial_out_ff), .con_tx_valid(con_tx_valid),
    .con_tx_byte(con_tx_byte), .con_tx_ready_ff(con_tx_ready_ff),
    .con_rx_valid_ff(con_rx_valid_ff),
    .con_rx_byte_ff(con_rx_byte_ff), .doze_ff(doze_ff));
  asp_companion i_comp (.clk(clk), .line_from_dev(api_serial_out_ff),
    .request_low(api_out_request_low_ff), .grant_low(api_out_grant_low),
    .line_to_dev(api_serial_in), .grant_tied(grant_tied));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic send_packet(input int first, input int last_row);
    int w;
    for (int r = first; r <= last_row; r++) begin
      @(negedge clk);
      tx_valid = 1'b1;
      tx_byte = rows[r].b;
      tx_last = rows[r].last;
      w = 0;
      do begin
        @(negedge clk);
        w++;
      end while (tx_ready_ff !== 1'b1 && w < 20000);
      chk("byte accepted", {15'h0000, tx_ready_ff}, 16'h0001);
      @(posedge clk);
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic wait_req_high();
    int w;
    w = 0;
    while (api_out_request_low_ff !== 1'b1 && w < 30000) begin
      @(negedge clk);
      w++;
    end
  endtask
  task automatic check_line(input int first, input int last_row);
    logic [7:0] exp[$];
    exp.push_back(asp_pkg::HDLC_FLAG);
    for (int r = first; r <= last_row; r++) begin
      if (rows[r].n == 2) begin
        exp.push_back(rows[r].on_line[15:8]);
      end
      exp.push_back(rows[r].on_line[7:0]);
    end
    exp.push_back(asp_pkg::HDLC_FLAG);
    chk("line byte count", 16'(i_comp.got.size()), 16'(exp.size()));
    foreach (exp[i]) chk("line byte", {8'h00, i_comp.got[i]}, {8'h00, exp[i]});
    i_comp.got.delete();
  endtask
  // Strobes are read mid-cycle, once each, after they have settled
  always @(negedge clk) begin
    if (rx_valid_ff === 1'b1) begin
      rx_q.push_back(rx_byte_ff);
    end
    if (rx_end_ff === 1'b1) begin
      rx_ends++;
    end
    if (con_rx_valid_ff === 1'b1) begin
      con_rx_cnt++;
    end
    cycles++;
    if (cycles == 98000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    tx_last = 1'b0;
    api_in_request_low = 1'b1;
    grant_tied = 1'b0;
    con_in = 1'b1;
    con_tx_valid = 1'b0;
    con_tx_byte = 8'hA5;
    repeat (16) @(negedge clk);
    chk("tx request idle", {15'h0000, api_out_request_low_ff}, 16'h0001);
    chk("tx line idle", {15'h0000, api_serial_out_ff}, 16'h0001);
    chk("rx grant idle", {15'h0000, api_in_grant_low_ff}, 16'h0001);
    chk("tx ready in reset", {15'h0000, tx_ready_ff}, 16'h0000);
    chk("doze in reset", {15'h0000, doze_ff}, 16'h0001);
    chk("console idle", {15'h0000, console_serial_out_ff}, 16'h0001);
    rst_n = 1'b1;
    api_in_request_low = 1'b0;
    repeat (5) @(negedge clk);
    chk("rx grant given", {15'h0000, api_in_grant_low_ff}, 16'h0000);
    api_in_request_low = 1'b1;
    repeat (5) @(negedge clk);
    chk("rx grant dropped", {15'h0000, api_in_grant_low_ff}, 16'h0001);
    fork
      send_packet(0, 1);
      for (int i = 0; i < 4; i++) i_comp.send_byte(rx_in[i]);
      begin
        wait (api_out_request_low_ff === 1'b0);
        repeat (500) @(negedge clk);
        chk("held until grant", {15'h0000, api_serial_out_ff}, 16'h0001);
        repeat (3000) @(negedge clk);
        chk("awake in transfer", {15'h0000, doze_ff}, 16'h0000);
      end
      begin
        // A low pulse far shorter than half a bit is no start bit
        con_in = 1'b0;
        repeat (200) @(negedge clk);
        con_in = 1'b1;
        repeat (asp_pkg::CON_DIV) @(negedge clk);
        chk("console false start", 16'(con_rx_cnt), 16'h0000);
        chk("console rx byte", {8'h00, con_rx_byte_ff}, 16'h0000);
      end
    join
    wait_req_high();
    check_line(0, 1);
    chk("rx byte count", 16'(rx_q.size()), 16'h0001);
    chk("rx unescaped", {8'h00, rx_q[0]}, 16'h007E);
    chk("rx packet ends", 16'(rx_ends), 16'h0001);
    grant_tied = 1'b1;
    fork
      send_packet(2, 2);
      begin
        k = 0;
        while (api_out_request_low_ff === 1'b1 && k < 30000) begin
          @(negedge clk);
          k++;
        end
        chk("gap long enough", 16'(k >= 500), 16'h0001);
      end
      begin
        // A whole console byte outlasts the run: start and two data bits only
        chk("console ready", {15'h0000, con_tx_ready_ff}, 16'h0001);
        @(negedge clk);
        con_tx_valid = 1'b1;
        @(negedge clk);
        con_tx_valid = 1'b0;
        chk("console ready dropped", {15'h0000, con_tx_ready_ff}, 16'h0000);
        repeat (asp_pkg::CON_DIV / 2) @(negedge clk);
        chk("console start bit", {15'h0000, console_serial_out_ff}, 16'h0000);
        repeat (asp_pkg::CON_DIV) @(negedge clk);
        chk("console bit 0", {15'h0000, console_serial_out_ff}, 16'h0001);
        repeat (asp_pkg::CON_DIV) @(negedge clk);
        chk("console bit 1", {15'h0000, console_serial_out_ff}, 16'h0000);
      end
    join
    wait_req_high();
    check_line(2, 2);
    // Mid-run reset cuts the console byte still in flight
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("console cut by reset", {15'h0000, console_serial_out_ff}, 16'h0001);
    chk("console ready in reset", {15'h0000, con_tx_ready_ff}, 16'h0000);
    chk("tx request after reset", {15'h0000, api_out_request_low_ff}, 16'h0001);
    chk("doze after reset", {15'h0000, doze_ff}, 16'h0001);
    rst_n = 1'b1;
    api_in_request_low = 1'b0;
    repeat (5) @(negedge clk);
    chk("woken by request", {15'h0000, doze_ff}, 16'h0000);
    chk("rx grant after reset", {15'h0000, api_in_grant_low_ff}, 16'h0000);
    api_in_request_low = 1'b1;
    repeat (12500) @(negedge clk);
    chk("back in doze", {15'h0000, doze_ff}, 16'h0001);
    report_and_stop();
  end
endmodule
